// >>> core/dpscd_core.sv
// serial command decoder for a dual 64-tap digital potentiometer
// Summary of operation
// - wiper read: prefix 0101, address, opcode 1001; device returns 00 plus six bits.
// - wiper write: opcode 1010, then data byte; device acknowledges each byte.
// - stored setting read: opcode 1011 with slot and pot; returns 00 plus value.
// - stored setting write: opcode 1100 with slot, pot, data byte; each byte acknowledged.
// - opcode 1101 copies selected stored setting into that pot's wiper.
// - opcode 1110 copies selected pot's wiper into the chosen stored slot.
// - opcode 0001 loads both wipers from their settings in the chosen slot.
// - opcode 1000 saves both wipers into their settings in the chosen slot.
// - opcode 0010 enters stepping; each received bit moves the wiper one step unless it is already at that end.
// - nonvolatile programming begins only after the frame's stop condition.
// - step bit high moves toward high end, low toward low end.
// - nonvolatile update completes within five milliseconds.
// - after power-up each wiper loads from its slot zero setting.
`timescale 1ns/1ns
module dpscd_core #(
   parameter int unsigned NV_WRITE_CYCLES = dpscd_pkg::NV_WRITE_CYCLES
) (
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst_b,
   // serial bus
   input  wire logic            scl,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe_b,
   // address straps
   input  wire logic            address_strap_bit3,
   input  wire logic            address_strap_bit2,
   input  wire logic            address_strap_bit1,
   input  wire logic            address_strap_bit0,
   // wiper positions and nonvolatile status
   output logic [1:0][5:0]      wiper_position_register,
   output logic                 nv_busy
);

   localparam int unsigned NV_CW = $clog2(NV_WRITE_CYCLES + 1);
   localparam logic [NV_CW-1:0] NV_LAST = NV_CW'(NV_WRITE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection

   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic       scl_prev;
   logic       sda_prev;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         pin_meta <= 6'h3F;
         pin_sync <= 6'h3F;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end
      else
      begin
         pin_meta <= {scl, sda_in, address_strap_bit3, address_strap_bit2,
                      address_strap_bit1, address_strap_bit0};
         pin_sync <= pin_meta;
         scl_prev <= pin_sync[5];
         sda_prev <= pin_sync[4];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic [3:0] strap;
   logic       scl_rise;
   logic       scl_fall;
   logic       frame_start;
   logic       frame_stop;

   assign scl_s       = pin_sync[5];
   assign sda_s       = pin_sync[4];
   assign strap       = pin_sync[3:0];
   assign scl_rise    = scl_s & ~scl_prev;
   assign scl_fall    = ~scl_s & scl_prev;
   assign frame_start = scl_s & scl_prev & sda_prev & ~sda_s;
   assign frame_stop  = scl_s & scl_prev & ~sda_prev & sda_s;

   ////////////////////////////////////////////////////////////////////////////
   // frame state machine

   dpscd_pkg::dpscd_state_t  state;
   dpscd_pkg::dpscd_state_t  ack_next;
   dpscd_pkg::dpscd_instr_t  instr;
   dpscd_pkg::dpscd_nv_req_t nv_req;
   logic                     ack_on;
   logic [2:0]               bit_cnt;
   logic [7:0]               shreg;
   logic [7:0]               tx;
   logic                     nv_pend;
   logic                     exec;
   logic [3:0]               exec_op;
   logic [1:0]               exec_slot;
   logic                     exec_pot;
   logic [5:0]               exec_data;
   logic                     step_up;
   logic                     step_dn;
   logic                     step_dir;
   logic [1:0][3:0][5:0]     setting;
   logic                     nv_commit;

   logic [7:0]               byte_in;
   dpscd_pkg::dpscd_instr_t  byte_instr;
   logic [1:0]               in_slot;
   logic                     in_pot;

   assign byte_in    = {shreg[6:0], sda_s};
   assign byte_instr = byte_in;
   assign in_slot    = {byte_instr.slot_select_high_bit, byte_instr.slot_select_low_bit};
   assign in_pot     = byte_instr.pot_select_bit;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state     <= dpscd_pkg::ST_INIT;
         ack_next  <= dpscd_pkg::ST_IDLE;
         ack_on    <= 1'b0;
         bit_cnt   <= dpscd_pkg::BIT_FIRST;
         shreg     <= 8'h00;
         tx        <= 8'h00;
         instr     <= '0;
         nv_req    <= '0;
         nv_pend   <= 1'b0;
         exec      <= 1'b0;
         exec_op   <= 4'h0;
         exec_slot <= 2'h0;
         exec_pot  <= 1'b0;
         exec_data <= 6'h00;
         step_up   <= 1'b0;
         step_dn   <= 1'b0;
         step_dir  <= 1'b0;
         sda_out   <= 1'b1;
         sda_oe_b  <= 1'b1;
      end
      else
      begin
         exec    <= 1'b0;
         step_up <= 1'b0;
         step_dn <= 1'b0;
         if (frame_stop)
         begin
            state    <= dpscd_pkg::ST_IDLE;
            ack_on   <= 1'b0;
            nv_pend  <= 1'b0;
            sda_out  <= 1'b1;
            sda_oe_b <= 1'b1;
         end
         else if (frame_start)
         begin
            state    <= dpscd_pkg::ST_ADDR;
            bit_cnt  <= dpscd_pkg::BIT_FIRST;
            ack_on   <= 1'b0;
            nv_pend  <= 1'b0;
            sda_out  <= 1'b1;
            sda_oe_b <= 1'b1;
         end
         else
         begin
            case (state)
               dpscd_pkg::ST_INIT:
                  state <= dpscd_pkg::ST_IDLE;
               dpscd_pkg::ST_ADDR:
                  if (scl_rise)
                  begin
                     bit_cnt <= bit_cnt + 3'h1;
                     shreg   <= byte_in;
                     if (bit_cnt == dpscd_pkg::BIT_LAST)
                     begin
                        // busy programming: stay silent so the host polls
                        if (byte_in[7:4] == dpscd_pkg::DEV_PREFIX && byte_in[3:0] == strap
                            && !nv_busy)
                        begin
                           state    <= dpscd_pkg::ST_ACK;
                           ack_next <= dpscd_pkg::ST_INSTR;
                        end
                        else
                           state <= dpscd_pkg::ST_IGNORE;
                     end
                  end
               dpscd_pkg::ST_INSTR:
                  if (scl_rise)
                  begin
                     bit_cnt <= bit_cnt + 3'h1;
                     shreg   <= byte_in;
                     if (bit_cnt == dpscd_pkg::BIT_LAST)
                     begin
                        instr     <= byte_instr;
                        state     <= dpscd_pkg::ST_ACK;
                        exec_op   <= byte_instr.op;
                        exec_slot <= in_slot;
                        exec_pot  <= in_pot;
                        case (byte_instr.op)
                           dpscd_pkg::OP_RD_WIPER:
                           begin
                              ack_next <= dpscd_pkg::ST_RDATA;
                              tx <= {dpscd_pkg::PAD_ZERO, wiper_position_register[in_pot]};
                           end
                           dpscd_pkg::OP_RD_SLOT:
                           begin
                              ack_next <= dpscd_pkg::ST_RDATA;
                              tx <= {dpscd_pkg::PAD_ZERO, setting[in_pot][in_slot]};
                           end
                           dpscd_pkg::OP_WR_WIPER, dpscd_pkg::OP_WR_SLOT:
                              ack_next <= dpscd_pkg::ST_WDATA;
                           dpscd_pkg::OP_SLOT_TO_WIPER, dpscd_pkg::OP_GANG_LOAD:
                           begin
                              ack_next <= dpscd_pkg::ST_IGNORE;
                              exec     <= 1'b1;
                           end
                           dpscd_pkg::OP_WIPER_TO_SLOT:
                           begin
                              ack_next        <= dpscd_pkg::ST_IGNORE;
                              nv_pend         <= 1'b1;
                              nv_req.slot     <= in_slot;
                              nv_req.pot_mask <= in_pot ? 2'h2 : 2'h1;
                              nv_req.value    <= wiper_position_register;
                           end
                           dpscd_pkg::OP_GANG_SAVE:
                           begin
                              ack_next        <= dpscd_pkg::ST_IGNORE;
                              nv_pend         <= 1'b1;
                              nv_req.slot     <= in_slot;
                              nv_req.pot_mask <= 2'h3;
                              nv_req.value    <= wiper_position_register;
                           end
                           dpscd_pkg::OP_STEP:
                              ack_next <= dpscd_pkg::ST_STEP;
                           default:
                              state <= dpscd_pkg::ST_IGNORE;
                        endcase
                     end
                  end
               dpscd_pkg::ST_WDATA:
                  if (scl_rise)
                  begin
                     bit_cnt <= bit_cnt + 3'h1;
                     shreg   <= byte_in;
                     if (bit_cnt == dpscd_pkg::BIT_LAST)
                     begin
                        state     <= dpscd_pkg::ST_ACK;
                        ack_next  <= dpscd_pkg::ST_IGNORE;
                        exec_data <= byte_in[5:0];
                        if (instr.op == dpscd_pkg::OP_WR_WIPER)
                           exec <= 1'b1;
                        else
                        begin
                           nv_pend         <= 1'b1;
                           nv_req.slot     <= exec_slot;
                           nv_req.pot_mask <= exec_pot ? 2'h2 : 2'h1;
                           nv_req.value    <= {byte_in[5:0], byte_in[5:0]};
                        end
                     end
                  end
               dpscd_pkg::ST_ACK:
                  if (scl_fall)
                  begin
                     if (!ack_on)
                     begin
                        ack_on   <= 1'b1;
                        sda_out  <= 1'b0;
                        sda_oe_b <= 1'b0;
                     end
                     else
                     begin
                        ack_on <= 1'b0;
                        state  <= ack_next;
                        if (ack_next == dpscd_pkg::ST_RDATA)
                        begin
                           sda_out  <= tx[7];
                           sda_oe_b <= tx[7];
                           tx       <= {tx[6:0], 1'b0};
                        end
                        else
                        begin
                           sda_out  <= 1'b1;
                           sda_oe_b <= 1'b1;
                        end
                     end
                  end
               dpscd_pkg::ST_RDATA:
                  if (scl_rise)
                  begin
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == dpscd_pkg::BIT_LAST)
                        state <= dpscd_pkg::ST_MACK;
                  end
                  else if (scl_fall)
                  begin
                     // open drain: a one is sent by letting go of the line
                     sda_out  <= tx[7];
                     sda_oe_b <= tx[7];
                     tx       <= {tx[6:0], 1'b0};
                  end
               dpscd_pkg::ST_MACK:
                  if (scl_fall)
                  begin
                     sda_out  <= 1'b1;
                     sda_oe_b <= 1'b1;
                     state    <= dpscd_pkg::ST_IGNORE;
                  end
               dpscd_pkg::ST_STEP:
                  // direction taken at the rise, step applied at the fall, so the
                  // rising clock of the closing stop never moves the wiper
                  if (scl_rise)
                     step_dir <= sda_s;
                  else if (scl_fall)
                  begin
                     step_up <= step_dir;
                     step_dn <= ~step_dir;
                  end
               dpscd_pkg::ST_IDLE, dpscd_pkg::ST_IGNORE:
                  state <= state;
               default:
                  state <= dpscd_pkg::ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // nonvolatile programming timer

   logic [NV_CW-1:0] nv_cnt;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         nv_busy   <= 1'b0;
         nv_cnt    <= '0;
         nv_commit <= 1'b0;
      end
      else
      begin
         nv_commit <= 1'b0;
         if (!nv_busy && frame_stop && nv_pend)
         begin
            nv_busy <= 1'b1;
            nv_cnt  <= '0;
         end
         else if (nv_busy)
         begin
            nv_cnt <= nv_cnt + NV_CW'(1);
            if (nv_cnt == NV_LAST)
            begin
               nv_busy   <= 1'b0;
               nv_commit <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-pot wiper and stored settings

   for (genvar p = 0; p < dpscd_pkg::NUM_POTS; p++)
   begin : g_pot
      localparam logic POT_ID = 1'(p);

      always_ff @(posedge core_clk)
      begin
         if (!rst_b)
            setting[p] <= {dpscd_pkg::NUM_SLOTS{dpscd_pkg::SETTING_RESET}};
         else if (nv_commit && nv_req.pot_mask[p])
            setting[p][nv_req.slot] <= nv_req.value[p];
      end

      always_ff @(posedge core_clk)
      begin
         if (!rst_b)
            wiper_position_register[p] <= dpscd_pkg::WIPER_RESET;
         else if (state == dpscd_pkg::ST_INIT)
            wiper_position_register[p] <= setting[p][dpscd_pkg::SLOT_ZERO];
         else if (exec)
         begin
            case (exec_op)
               dpscd_pkg::OP_WR_WIPER:
                  if (exec_pot == POT_ID)
                     wiper_position_register[p] <= exec_data;
               dpscd_pkg::OP_SLOT_TO_WIPER:
                  if (exec_pot == POT_ID)
                     wiper_position_register[p] <= setting[p][exec_slot];
               dpscd_pkg::OP_GANG_LOAD:
                  wiper_position_register[p] <= setting[p][exec_slot];
               default:
                  wiper_position_register[p] <= wiper_position_register[p];
            endcase
         end
         else if (instr.pot_select_bit == POT_ID)
         begin
            if (step_up && wiper_position_register[p] != dpscd_pkg::POS_MAX)
               wiper_position_register[p] <= wiper_position_register[p] + dpscd_pkg::POS_STEP;
            else if (step_dn && wiper_position_register[p] != dpscd_pkg::POS_MIN)
               wiper_position_register[p] <= wiper_position_register[p] - dpscd_pkg::POS_STEP;
         end
      end
   end

endmodule // dpscd_core

// >>> core/dpscd_pkg.sv
// constants and types for the dual pot serial command decoder
package dpscd_pkg;

   // timing
   localparam int unsigned CLK_HZ           = 20_000_000;
   localparam int unsigned NV_WRITE_TIME_US = 5000;
   localparam int unsigned NV_WRITE_CYCLES  = NV_WRITE_TIME_US * (CLK_HZ / 1_000_000);

   // frame layout
   localparam logic [3:0] DEV_PREFIX = 4'h5;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [2:0] BIT_FIRST  = 3'h0;

   // instruction opcodes, upper nibble of the instruction byte
   localparam logic [3:0] OP_RD_WIPER      = 4'h9;
   localparam logic [3:0] OP_WR_WIPER      = 4'hA;
   localparam logic [3:0] OP_RD_SLOT       = 4'hB;
   localparam logic [3:0] OP_WR_SLOT       = 4'hC;
   localparam logic [3:0] OP_SLOT_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_WIPER_TO_SLOT = 4'hE;
   localparam logic [3:0] OP_GANG_LOAD     = 4'h1;
   localparam logic [3:0] OP_GANG_SAVE     = 4'h8;
   localparam logic [3:0] OP_STEP          = 4'h2;

   // positions and reset values
   localparam logic [5:0] POS_MIN       = 6'h00;
   localparam logic [5:0] POS_MAX       = 6'h3F;
   localparam logic [5:0] POS_STEP      = 6'h01;
   localparam logic [5:0] WIPER_RESET   = 6'h00;
   localparam logic [5:0] SETTING_RESET = 6'h00;
   localparam logic [1:0] SLOT_ZERO     = 2'h0;
   localparam logic [1:0] PAD_ZERO      = 2'h0;
   localparam int unsigned NUM_POTS     = 2;
   localparam int unsigned NUM_SLOTS    = 4;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_ADDR   = 4'h1,
      ST_ACK    = 4'h3,
      ST_INSTR  = 4'h2,
      ST_WDATA  = 4'h6,
      ST_RDATA  = 4'h7,
      ST_MACK   = 4'h5,
      ST_STEP   = 4'h4,
      ST_IGNORE = 4'hC,
      ST_INIT   = 4'hD
   } dpscd_state_t;

   typedef struct packed {
      logic [3:0] op;
      logic       slot_select_high_bit;
      logic       slot_select_low_bit;
      logic       zero;
      logic       pot_select_bit;
   } dpscd_instr_t;

   typedef struct packed {
      logic [1:0]      pot_mask;
      logic [1:0]      slot;
      logic [1:0][5:0] value;
   } dpscd_nv_req_t;

endpackage

// >>> tb/dpscd_core_monitor.sv
// port checker for the serial command decoder
`timescale 1ns/1ns
module dpscd_core_monitor #(
   parameter int unsigned NV_WRITE_CYCLES = 20
) (
   // clock and reset
   input wire logic            core_clk,
   input wire logic            rst_b,
   // serial bus
   input wire logic            scl,
   input wire logic            sda_in,
   input wire logic            sda_out,
   input wire logic            sda_oe_b,
   // address straps
   input wire logic            address_strap_bit3,
   input wire logic            address_strap_bit2,
   input wire logic            address_strap_bit1,
   input wire logic            address_strap_bit0,
   // wiper positions and nonvolatile status
   input wire logic [1:0][5:0] wiper_position_register,
   input wire logic            nv_busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic        scl_q;
   logic        sda_q;
   logic [7:0]  t_rise;
   logic [7:0]  t_fall;
   logic [7:0]  t_stop;
   logic [31:0] busy_len;
   // saturating age counters, so stale events never wrap into range
   function automatic logic [7:0] tick(input logic hit, input logic [7:0] t);
      return hit ? 8'h00 : ((t == 8'hFF) ? t : t + 8'h01);
   endfunction
   always_ff @(posedge core_clk)
   begin
      scl_q <= scl;
      sda_q <= sda_in;
      if (!rst_b)
      begin
         t_rise <= 8'hFF;
         t_fall <= 8'hFF;
         t_stop <= 8'hFF;
      end
      else
      begin
         t_rise <= tick(scl && !scl_q, t_rise);
         t_fall <= tick(!scl && scl_q, t_fall);
         t_stop <= tick(scl && scl_q && sda_in && !sda_q, t_stop);
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (!rst_b || !nv_busy)
         busy_len <= 32'h0;
      else
         busy_len <= busy_len + 32'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_reset_values:
      assert property (disable iff (1'b0) !rst_b |=> sda_oe_b && sda_out && !nv_busy
         && wiper_position_register == 12'h000) else $error("outputs not at reset values");
   a_open_drain_low:
      assert property (!sda_oe_b |-> !sda_out) else $error("sda driven high");
   a_ack_holds:
      assert property ($fell(sda_oe_b) |=> !sda_oe_b [*3]) else $error("drive too short");
   a_drive_after_fall:
      assert property ($fell(sda_oe_b) |-> t_fall <= 8'h08) else $error("drive not after scl fall");
   a_release_at_stop:
      assert property (t_stop == 8'h06 |-> sda_oe_b) else $error("sda held after stop");
   a_busy_after_stop:
      assert property ($rose(nv_busy) |-> t_stop <= 8'h0A) else $error("programming without stop");
   a_nv_duration:
      assert property ($fell(nv_busy) |-> busy_len >= NV_WRITE_CYCLES - 1
         && busy_len <= NV_WRITE_CYCLES + 1) else $error("programming time wrong");
   a_busy_no_ack:
      assert property (nv_busy |-> sda_oe_b) else $error("acknowledge while programming");
   a_wiper_on_clock:
      assert property ($changed(wiper_position_register) |-> t_rise <= 8'h0A)
         else $error("wiper moved without scl rise");
   c_program: cover property ($rose(nv_busy));
   c_ack: cover property ($fell(sda_oe_b));
   c_wiper: cover property ($changed(wiper_position_register));
endmodule // dpscd_core_monitor

bind dpscd_core dpscd_core_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_mon (
   .core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_b(sda_oe_b), .address_strap_bit3(address_strap_bit3),
   .address_strap_bit2(address_strap_bit2), .address_strap_bit1(address_strap_bit1),
   .address_strap_bit0(address_strap_bit0),
   .wiper_position_register(wiper_position_register), .nv_busy(nv_busy));

// >>> tb/dpscd_core_tb.sv
// self-checking bench for the serial command decoder
`timescale 1ns/1ns
module dpscd_core_tb;
   logic            core_clk;
   logic            rst_b;
   logic            scl;
   logic            sda_drv;
   logic            sda_out;
   logic            sda_oe_b;
   logic            nv_busy;
   logic [3:0]      strap;
   logic [1:0][5:0] wiper;
   logic [7:0]      d;
   logic [2:0]      ak;
   logic            r;
   wire             sda;
   int              miscompares;
   int              comparisons;
   int              cycles;
   assign sda = sda_drv & (sda_oe_b | sda_out);
   dpscd_core #(.NV_WRITE_CYCLES(20)) i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_b(sda_oe_b), .address_strap_bit3(strap[3]), .address_strap_bit2(strap[2]),
      .address_strap_bit1(strap[1]), .address_strap_bit0(strap[0]),
      .wiper_position_register(wiper), .nv_busy(nv_busy));
   dpscd_host i_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         conclude();
      end
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // start, address, instruction and optional data; stop left to caller
   task automatic frame(input logic [3:0] adr, input logic [7:0] ins, input logic wdat,
                        input logic [7:0] dat);
      ak = 3'h0;
      i_host.start();
      i_host.wr_byte({dpscd_pkg::DEV_PREFIX, adr}, ak[0]);
      if (ak[0])
         i_host.wr_byte(ins, ak[1]);
      if (ak[0] && wdat)
         i_host.wr_byte(dat, ak[2]);
   endtask
   task automatic cmd(input logic [7:0] ins, input logic wdat, input logic [7:0] dat);
      frame(strap, ins, wdat, dat);
      i_host.stop();
      check(12'(ak), 12'({wdat, 2'h3}));
   endtask
   task automatic rd(input logic [7:0] ins, input logic [5:0] exp);
      frame(strap, ins, 1'b0, 8'h00);
      i_host.rd_byte(d);
      i_host.stop();
      check(12'(d), 12'({2'h0, exp}));
   endtask
   task automatic step(input logic b, input int n);
      repeat (n) i_host.bit_io(b, r);
      // the step lands a few cycles after the last clock fall
      i_host.w(4);
   endtask
   initial
   begin
      rst_b = 1'b0;
      strap = 4'hA;
      miscompares = 0;
      comparisons = 0;
      cycles = 0;
      repeat (4) @(posedge core_clk);
      #2 rst_b = 1'b1;
      i_host.w(10);
      check(wiper, 12'h000);
      cmd(8'hA0, 1'b1, 8'hD5);
      cmd(8'hA1, 1'b1, 8'h2A);
      check(wiper, 12'hA95);
      rd(8'h91, 6'h2A);
      rd(8'h90, 6'h15);
      // foreign address must be ignored entirely
      frame(4'h3, 8'hA0, 1'b1, 8'h01);
      i_host.stop();
      check(12'(ak), 12'h000);
      check(wiper, 12'hA95);
      // new strap value takes effect from the next frame
      strap = 4'h3;
      rd(8'h90, 6'h15);
      // slot write: programming may only start after stop
      frame(strap, 8'hC8, 1'b1, 8'h33);
      check(12'(ak), 12'h007);
      i_host.w(30);
      check(12'(nv_busy), 12'h000);
      i_host.stop();
      check(12'(nv_busy), 12'h001);
      i_host.w(30);
      check(12'(nv_busy), 12'h000);
      rd(8'hB8, 6'h33);
      cmd(8'hD8, 1'b0, 8'h00);
      check(wiper, 12'hAB3);
      cmd(8'hE5, 1'b0, 8'h00);
      i_host.w(30);
      rd(8'hB5, 6'h2A);
      cmd(8'h8C, 1'b0, 8'h00);
      i_host.w(30);
      cmd(8'hA0, 1'b1, 8'h01);
      cmd(8'hA1, 1'b1, 8'h3E);
      check(wiper, 12'hF81);
      rd(8'hBC, 6'h33);
      rd(8'hBD, 6'h2A);
      cmd(8'h1C, 1'b0, 8'h00);
      check(wiper, 12'hAB3);
      // stepping at both ends of the range
      cmd(8'hA0, 1'b1, 8'h3E);
      cmd(8'hA1, 1'b1, 8'h01);
      frame(strap, 8'h20, 1'b0, 8'h00);
      check(12'(ak), 12'h003);
      step(1'b1, 3);
      check(wiper, 12'h07F);
      step(1'b0, 2);
      check(wiper, 12'h07D);
      i_host.stop();
      frame(strap, 8'h21, 1'b0, 8'h00);
      step(1'b0, 3);
      check({6'h00, wiper[1]}, 12'h000);
      step(1'b1, 1);
      check({6'h00, wiper[1]}, 12'h001);
      i_host.stop();
      conclude();
   end
endmodule // dpscd_core_tb

// >>> tb/dpscd_host.sv
// host bus master model: drives scl, open-drain sda with pull-up
`timescale 1ns/1ns
module dpscd_host (
   // clock
   input  wire logic core_clk,
   // serial bus
   input  wire logic sda,
   output logic      scl,
   output logic      sda_drv
);
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   // data moves mid-low so it never looks like start or stop
   task automatic bit_io(input logic b, output logic r);
      w(2);
      sda_drv = b;
      w(2);
      scl = 1'b1;
      w(4);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start;
      if (!scl)
      begin
         w(2);
         sda_drv = 1'b1;
         w(2);
         scl = 1'b1;
         w(4);
      end
      sda_drv = 1'b0;
      w(4);
      scl = 1'b0;
   endtask
   task automatic stop;
      w(2);
      sda_drv = 1'b0;
      w(2);
      scl = 1'b1;
      w(4);
      sda_drv = 1'b1;
      w(8);
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(1'b1, r);
   endtask
endmodule // dpscd_host
